//--- design/dac_seg_pkg.sv
// Constants and carrier types for the dual segmented converter front end.
// Assumes a single synchronous clock domain and a sample source outside.
// Functional notes
// - Two independent channels, each with own register, decoder and output selects.
// - Input register captures the sample on rising clock edge, holds until next.
// - Upper five bits become 31 equal unit enables, thermometer coded.
// - Lower five bits drive binary-weighted enables directly, bit n weight 2^n.
// - Going from low bits 31 upward clears all binary enables, adds one unit.
// - Enabled sources steer to output A, disabled ones to output B.
// - Each source goes to exactly one output; outputs are complementary.
// - Reference select low picks internal reference, high picks external.
package dac_seg_pkg;
   localparam int SAMPLE_W = 10;
   localparam int SEG_W = 5;
   localparam int LSB_W = SAMPLE_W - SEG_W;
   localparam int UNIT_N = (1 << SEG_W) - 1;
   localparam int FIFO_DEPTH = 8;
   localparam int MAX_RATE_MSPS = 125;
   localparam int CLK_MHZ = 250;
   // Least clock cycles between samples at the documented maximum rate
   localparam int MIN_GAP_CYC = (CLK_MHZ + MAX_RATE_MSPS - 1) / MAX_RATE_MSPS;
   localparam logic [SAMPLE_W-1:0] SAMPLE_RST = 10'h000;

   typedef struct packed {
      logic [SAMPLE_W-1:0] q_bits;
      logic [SAMPLE_W-1:0] i_bits;
   } sample_pair_t;

   typedef struct packed {
      logic [UNIT_N-1:0] unit_en;
      logic [LSB_W-1:0] bin_en;
   } chan_sel_t;
endpackage

//--- design/dac_seg_top.sv
// Sample FIFO and dual segmented decoder driving current steering selects.
// Assumes sample pairs arrive with valid and ready, synchronous to i_mclk.
`timescale 1ns/10ps
`default_nettype none

module dac_sample_fifo #(
   parameter int WIDTH = 20,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_n,
   // Fill side
   input wire logic i_valid,
   output logic o_ready,
   input wire logic [WIDTH-1:0] i_data,
   // Drain side
   output logic o_valid,
   input wire logic i_ready,
   output logic [WIDTH-1:0] o_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
   logic [AW:0] cnt_r, cnt_nxt;
   logic push, pop;

   // Pointer and occupancy update; full and empty come from the count
   always_comb begin
      push = i_valid && o_ready;
      pop = o_valid && i_ready;
      wp_nxt = push ? AW'((int'(wp_r) + 1) % DEPTH) : wp_r;
      rp_nxt = pop ? AW'((int'(rp_r) + 1) % DEPTH) : rp_r;
      cnt_nxt = cnt_r;
      if (push && !pop) begin
         cnt_nxt = cnt_r + 1'b1;
      end else if (pop && !push) begin
         cnt_nxt = cnt_r - 1'b1;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end else begin
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // Storage has no reset; data is only read when the count says it is valid
   always_ff @(posedge i_mclk) begin
      if (push) begin
         mem_r[wp_r] <= i_data;
      end
   end

   assign o_ready = (cnt_r != (AW+1)'(DEPTH));
   assign o_valid = (cnt_r != '0);
   assign o_data = mem_r[rp_r];

   // Occupancy never leaves the storage range; a wrap here would lose pairs
   AST_FIFO_NO_OVERFLOW: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      cnt_r <= (AW+1)'(DEPTH))
      else $error("sample fifo count beyond depth");
   // A pop only ever takes a stored entry
   AST_FIFO_NO_UNDERFLOW: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      pop |-> cnt_r != '0)
      else $error("sample fifo popped while empty");
   // Full refuses a push: the count stays put unless a pop frees a slot
   AST_FIFO_FULL_HOLD: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (cnt_r == (AW+1)'(DEPTH) && !pop) |=> cnt_r == (AW+1)'(DEPTH))
      else $error("sample fifo full count moved");
endmodule

module dac_seg_top
   import dac_seg_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH
) (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_n,
   // Sample source stream
   input wire logic i_sample_valid,
   output logic o_sample_ready,
   input wire sample_pair_t i_sample_bits,
   // Reference control
   input wire logic i_reference_select,
   output logic o_use_external_ref,
   // Current steering selects, true side and complement side
   output chan_sel_t o_i_channel_true_current,
   output chan_sel_t o_i_channel_complement_current,
   output chan_sel_t o_q_channel_true_current,
   output chan_sel_t o_q_channel_complement_current
);
   sample_pair_t fifo_data;
   logic fifo_valid, fifo_ready, fifo_in_ready;
   logic [SAMPLE_W-1:0] smp_r [2];
   logic [SAMPLE_W-1:0] smp_nxt [2];
   logic [MIN_GAP_CYC-1:0] gap_r, gap_nxt;
   chan_sel_t true_r [2];
   chan_sel_t true_nxt [2];
   chan_sel_t comp_r [2];
   chan_sel_t comp_nxt [2];
   logic ref_r, ref_nxt, ready_r, ready_nxt;
   // Occupancy mirror so the registered ready is exact, not one cycle stale
   localparam int OCC_W = $clog2(DEPTH) + 1;
   logic [OCC_W-1:0] occ_r, occ_nxt;
   logic fifo_push, fifo_pop;

   // Thermometer decode of the segment field, used by both channels
   function automatic logic [UNIT_N-1:0] thermo(input logic [SEG_W-1:0] v);
      logic [UNIT_N-1:0] t;
      t = '0;
      for (int k = 0; k < UNIT_N; k++) begin
         t[k] = (int'(v) > k);
      end
      return t;
   endfunction

   dac_sample_fifo #(
      .WIDTH(2*SAMPLE_W),
      .DEPTH(DEPTH)
   ) u_fifo (
      .i_mclk(i_mclk),
      .i_rst_n(i_rst_n),
      .i_valid(fifo_push),
      .o_ready(fifo_in_ready),
      .i_data(i_sample_bits),
      .o_valid(fifo_valid),
      .i_ready(fifo_ready),
      .o_data(fifo_data)
   );

   // Drain one sample pair per conversion slot; spacing guards the max rate
   assign fifo_ready = gap_r[0];

   always_comb begin
      gap_nxt = {gap_r[0], gap_r[MIN_GAP_CYC-1:1]};
      if (MIN_GAP_CYC == 1) begin
         gap_nxt = '1;
      end
      smp_nxt[0] = smp_r[0];
      smp_nxt[1] = smp_r[1];
      if (fifo_valid && fifo_ready) begin
         smp_nxt[0] = fifo_data.i_bits;
         smp_nxt[1] = fifo_data.q_bits;
      end
      ref_nxt = i_reference_select;
      // Push only while the registered ready is high, so the source and
      // the FIFO always agree on which offers were taken
      fifo_push = i_sample_valid && ready_r;
      fifo_pop = fifo_valid && fifo_ready;
      occ_nxt = occ_r;
      if (fifo_push && !fifo_pop) begin
         occ_nxt = occ_r + 1'b1;
      end else if (fifo_pop && !fifo_push) begin
         occ_nxt = occ_r - 1'b1;
      end
      ready_nxt = (occ_nxt != OCC_W'(DEPTH));
   end

   // Per channel decode from the held sample; one instance per channel
   for (genvar c = 0; c < 2; c++) begin : g_chan
      always_comb begin
         true_nxt[c].unit_en = thermo(smp_r[c][SAMPLE_W-1:LSB_W]);
         true_nxt[c].bin_en = smp_r[c][LSB_W-1:0];
         comp_nxt[c] = ~true_nxt[c];
      end
   end

   // Register everything at one edge so decode glitches never reach switches
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         gap_r <= {{(MIN_GAP_CYC-1){1'b0}}, 1'b1};
         smp_r[0] <= SAMPLE_RST;
         smp_r[1] <= SAMPLE_RST;
         true_r[0] <= '0;
         true_r[1] <= '0;
         comp_r[0] <= '1;
         comp_r[1] <= '1;
         ref_r <= 1'b0;
         ready_r <= 1'b0;
         occ_r <= '0;
      end else begin
         gap_r <= gap_nxt;
         smp_r <= smp_nxt;
         true_r <= true_nxt;
         comp_r <= comp_nxt;
         ref_r <= ref_nxt;
         ready_r <= ready_nxt;
         occ_r <= occ_nxt;
      end
   end

   assign o_i_channel_true_current = true_r[0];
   assign o_i_channel_complement_current = comp_r[0];
   assign o_q_channel_true_current = true_r[1];
   assign o_q_channel_complement_current = comp_r[1];
   assign o_use_external_ref = ref_r;
   // Ready is registered from the occupancy mirror, so it equals the FIFO's
   // own room flag every cycle except the first after reset release, when it is still low, and an offer is never half taken
   assign o_sample_ready = ready_r;

   // Checks below watch the registered selects one edge after the held sample; capture, hold, rate and reference checks watch their own paths
   // Unit count equals segment field one cycle after capture
   AST_THERMO_COUNT: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      $countones(true_r[0].unit_en) == int'($past(smp_r[0][SAMPLE_W-1:LSB_W])))
      else $error("unit enable count mismatch");
   AST_BIN_DIRECT: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      true_r[1].bin_en == $past(smp_r[1][LSB_W-1:0]))
      else $error("binary enables do not follow low bits");
   AST_CARRY: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      ($past(smp_r[0][LSB_W-1:0]) == '1 &&
       $past(smp_r[0][SAMPLE_W-1:LSB_W]) != '1 &&
       smp_r[0] == SAMPLE_W'($past(smp_r[0]) + 1'b1))
      |=> (true_r[0].bin_en == '0 &&
           $countones(true_r[0].unit_en) == $countones($past(true_r[0].unit_en)) + 1))
      else $error("carry transition wrong");
   AST_COMPLEMENT: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (comp_r[0] == ~true_r[0]) && (comp_r[1] == ~true_r[1]))
      else $error("outputs not complementary");
   AST_STEER_ZERO: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      $past(smp_r[0]) == '0 |-> true_r[0] == '0 && comp_r[0] == '1)
      else $error("zero code not fully on complement");
   AST_CAPTURE: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      fifo_valid && fifo_ready |=> smp_r[1] == $past(fifo_data.q_bits))
      else $error("sample not captured");
   AST_HOLD: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      !(fifo_valid && fifo_ready) |=> $stable(smp_r[0]))
      else $error("sample not held");
   AST_RATE: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      fifo_ready |=> !fifo_ready)
      else $error("drain faster than max rate");
   AST_REF: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      o_use_external_ref == $past(i_reference_select))
      else $error("reference select not followed");
   AST_TOGETHER: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      $changed(true_r[0]) |-> $past(smp_r[0]) != $past(smp_r[0], 2))
      else $error("enables changed without a new sample");

   // Mirrors of the checks above on the other channel; the channels share no decode state
   AST_THERMO_COUNT_Q: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      $countones(true_r[1].unit_en) == int'($past(smp_r[1][SAMPLE_W-1:LSB_W])))
      else $error("q unit enable count mismatch");
   AST_BIN_DIRECT_I: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      true_r[0].bin_en == $past(smp_r[0][LSB_W-1:0]))
      else $error("i binary enables do not follow low bits");
   AST_CARRY_Q: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      ($past(smp_r[1][LSB_W-1:0]) == '1 &&
       $past(smp_r[1][SAMPLE_W-1:LSB_W]) != '1 &&
       smp_r[1] == SAMPLE_W'($past(smp_r[1]) + 1'b1))
      |=> (true_r[1].bin_en == '0 &&
           $countones(true_r[1].unit_en) == $countones($past(true_r[1].unit_en)) + 1))
      else $error("q carry transition wrong");
   AST_TOGETHER_Q: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      $changed(true_r[1]) |-> $past(smp_r[1]) != $past(smp_r[1], 2))
      else $error("q enables changed without a new sample");
   AST_CAPTURE_I: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      fifo_valid && fifo_ready |=> smp_r[0] == $past(fifo_data.i_bits))
      else $error("i sample not captured");
   AST_HOLD_Q: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      !(fifo_valid && fifo_ready) |=> $stable(smp_r[1]))
      else $error("q sample not held");
   // Unit enables always form a solid run from bit 0, never a gapped pattern
   AST_THERMO_SHAPE: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      ((true_r[0].unit_en & (true_r[0].unit_en + 1'b1)) == '0) &&
      ((true_r[1].unit_en & (true_r[1].unit_en + 1'b1)) == '0))
      else $error("unit enables not thermometer coded");
   // Full scale and mid scale codes land on the expected steering split
   AST_STEER_FULL: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      $past(smp_r[1]) == '1 |-> true_r[1] == '1 && comp_r[1] == '0)
      else $error("full code not fully on true side");
   AST_STEER_MID: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      $past(smp_r[0]) == SAMPLE_W'(1 << (SAMPLE_W-1)) |->
      $countones(true_r[0].unit_en) == (UNIT_N + 1) / 2 && true_r[0].bin_en == '0)
      else $error("mid code not split equally");
   // The registered ready must match the FIFO's own room flag every cycle,
   // except on the first edge after release while the flop catches up
   AST_READY_MATCH: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      $past(i_rst_n) |-> o_sample_ready == fifo_in_ready)
      else $error("ready disagrees with fifo room");

   // Cover points for the main scenarios

   COV_FULL: cover property (@(posedge i_mclk) disable iff (!i_rst_n) !fifo_in_ready);
   COV_FULL_SCALE: cover property (@(posedge i_mclk) disable iff (!i_rst_n)
      true_r[0] == '1);
   COV_MID: cover property (@(posedge i_mclk) disable iff (!i_rst_n)
      smp_r[1] == 10'h200);
   COV_CARRY: cover property (@(posedge i_mclk) disable iff (!i_rst_n)
      smp_r[0] == 10'h01F ##[1:8] smp_r[0] == 10'h020);
   COV_EXT_REF: cover property (@(posedge i_mclk) disable iff (!i_rst_n) o_use_external_ref);
endmodule

`default_nettype wire

//--- bench/sample_src.sv
// Sample source model: offers queued I/Q pairs with valid, holds until ready.
// Assumes the bench fills q and sets the spacing between offers.
`timescale 1ns/10ps
`default_nettype none
module sample_src
   import dac_seg_pkg::*;
(
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_n,
   // Stream to the converter
   input wire logic i_ready,
   input wire logic [3:0] i_gap,
   output logic o_valid,
   output sample_pair_t o_bits
);
   sample_pair_t q[$];
   int cnt = 0;
   initial begin
      o_valid = 1'b0;
      o_bits = '0;
   end
   // Offer only after the gap has run out; idle lines toggle so no stale value shows
   always @(posedge i_mclk) begin
      if (o_valid && i_ready) begin
         void'(q.pop_front());
         cnt = i_gap;
      end
      if (cnt > 0) cnt--;
      if (i_rst_n && cnt == 0 && q.size() > 0) begin
         o_valid <= 1'b1;
         o_bits <= q[0];
      end else begin
         o_valid <= 1'b0;
         o_bits <= ~o_bits;
      end
   end
endmodule
`default_nettype wire

//--- bench/tb_dual_dac_segment_decoder.sv
// Bench for the dual segmented decoder: reset, code table, burst, reference.
// Assumes the design files and the sample source model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module tb_dual_dac_segment_decoder;
   import dac_seg_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, ref_sel = 1'b0, rdy, vld, ext, saw_full = 1'b0;
   logic [3:0] gap = 4'h2;
   sample_pair_t bits;
   sample_pair_t exp[$];
   chan_sel_t it, ic, qt, qc;
   chan_sel_t last = '0;
   int num_errors = 0, total_checks = 0;
   always #2 clk = ~clk;
   sample_src src (.i_mclk(clk), .i_rst_n(rst_n), .i_ready(rdy), .i_gap(gap),
      .o_valid(vld), .o_bits(bits));
   dac_seg_top uut (.i_mclk(clk), .i_rst_n(rst_n), .i_sample_valid(vld),
      .o_sample_ready(rdy), .i_sample_bits(bits), .i_reference_select(ref_sel),
      .o_use_external_ref(ext), .o_i_channel_true_current(it),
      .o_i_channel_complement_current(ic), .o_q_channel_true_current(qt),
      .o_q_channel_complement_current(qc));
   // Reference decode kept apart from the design's own
   function automatic chan_sel_t dec(logic [SAMPLE_W-1:0] s);
      dec.bin_en = s[LSB_W-1:0];
      for (int k = 0; k < UNIT_N; k++) dec.unit_en[k] = (s[SAMPLE_W-1:LSB_W] > k);
   endfunction
   task automatic chk(string nm, logic [35:0] e, logic [35:0] s);
      total_checks++;
      if (e !== s) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic send(logic [9:0] i, logic [9:0] q);
      exp.push_back({q, i});
      src.q.push_back({q, i});
   endtask
   // Each change of the I selects retires one queued pair, in order
   always @(negedge clk) begin
      if (rst_n) begin
         if (it !== last) begin
            last = it;
            if (exp.size() == 0) chk("spare update", 36'h0, 36'h1);
            else begin
               bits_cmp(exp.pop_front());
            end
         end
         if (vld && !rdy) saw_full = 1'b1;
         chk("i complement", ~it, ic);
         chk("q complement", ~qt, qc);
      end
   end
   task automatic bits_cmp(sample_pair_t p);
      chk("i true", dec(p.i_bits), it);
      chk("q true", dec(p.q_bits), qt);
   endtask
   task automatic drain(string nm);
      for (int n = 0; n < 300 && exp.size() > 0; n++) @(posedge clk);
      chk("pairs left", 36'h0, 36'(exp.size()));
      $display("test %s done", nm);
   endtask
   task automatic t_reset;
      @(negedge clk);
      chk("reset true", 36'h0, it);
      chk("reset complement", ~36'h0, ic);
      chk("reset ready", 36'h0, 36'(rdy));
      chk("reset ext ref", 36'h0, 36'(ext));
      $display("test reset done");
   endtask
   task automatic t_codes;
      logic [9:0] c[6] = '{10'h01F, 10'h020, 10'h3FF, 10'h200, 10'h000, 10'h3E0};
      for (int k = 0; k < 6; k++) send(c[k], ~c[k]);
      drain("codes");
   endtask
   task automatic t_burst;
      @(posedge clk);
      gap <= 4'h1;
      saw_full = 1'b0;
      for (int k = 0; k < 24; k++) send(10'(k + 1), ~10'(k));
      drain("burst");
      chk("fifo refused", 36'h1, 36'(saw_full));
      gap <= 4'h2;
   endtask
   task automatic t_ref;
      @(posedge clk);
      ref_sel <= 1'b1;
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk("ext ref high", 36'h1, 36'(ext));
      @(posedge clk);
      ref_sel <= 1'b0;
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk("ext ref low", 36'h0, 36'(ext));
      $display("test reference done");
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (5) @(posedge clk);
      t_reset();
      @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      t_codes();
      t_burst();
      t_ref();
      tally_and_finish();
   end
   // Watchdog: tests need well under 2000 cycles
   initial begin
      #80000;
      num_errors++;
      tally_and_finish();
   end
endmodule
`default_nettype wire
